// file: tcs_pkg.sv
package tcs_pkg;

  // register page that holds both timers
  localparam logic [7:0] TCS_PAGE          = 8'h10;
  localparam int         TCS_NUM_TIMERS    = 2;

  // register addresses, index 0 is timer a, index 1 is timer b
  localparam logic [7:0] TCS_CTL_ADDR  [2] = '{8'hC8, 8'h91};
  localparam logic [7:0] TCS_CFG_ADDR  [2] = '{8'hC9, 8'h96};
  localparam logic [7:0] TCS_CAPL_ADDR [2] = '{8'hCA, 8'h92};
  localparam logic [7:0] TCS_CAPH_ADDR [2] = '{8'hCB, 8'h93};
  localparam logic [7:0] TCS_CNTL_ADDR [2] = '{8'hCC, 8'h94};
  localparam logic [7:0] TCS_CNTH_ADDR [2] = '{8'hCD, 8'h95};

  // timer a control is bit addressable: bit address base and group compare
  localparam logic [4:0] TCS_BIT_GROUP_A   = 5'h19;

  // control register fields
  localparam int         TCS_OVF_BIT       = 7;
  localparam int         TCS_EXT_FLAG_BIT  = 6;
  localparam int         TCS_EXT_EN_BIT    = 3;
  localparam int         TCS_RUN_BIT       = 2;
  localparam int         TCS_CT_SEL_BIT    = 1;
  localparam int         TCS_CPRL_BIT      = 0;
  localparam logic [7:0] TCS_CTL_MASK      = 8'hCF;

  // configuration register fields
  localparam int         TCS_MODE_LSB      = 3;
  localparam int         TCS_DCEN_BIT      = 0;
  localparam logic [7:0] TCS_CFG_MASK      = 8'h19;

  // reset values
  localparam logic [7:0]  TCS_CTL_RESET    = 8'h00;
  localparam logic [7:0]  TCS_CFG_RESET    = 8'h00;
  localparam logic [15:0] TCS_WORD_RESET   = 16'h0000;
  localparam logic [15:0] TCS_ALL_ONES     = 16'hFFFF;
  localparam logic [15:0] TCS_ALL_ZEROS    = 16'h0000;

  // clock mode select encodings
  localparam logic [1:0] TCS_MODE_DIV12    = 2'h0;
  localparam logic [1:0] TCS_MODE_DIV1     = 2'h1;
  localparam logic [1:0] TCS_MODE_EXT8     = 2'h2;
  localparam logic [1:0] TCS_MODE_DIV2     = 2'h3;

  // prescaler terminal counts, in cycles or external edges
  localparam logic [3:0] TCS_DIV12_LAST    = 4'hB;
  localparam logic [3:0] TCS_DIV2_LAST     = 4'h1;
  localparam logic [3:0] TCS_EXT8_LAST     = 4'h7;
  localparam logic [3:0] TCS_PRE_RESET     = 4'h0;

endpackage : tcs_pkg

// file: tcs_tick_if.sv
`timescale 1ns/1ps
// carries the clock mode to a prescaler and its count tick back
interface tcs_tick_if;
  logic [1:0] clk_mode;   // selected timer clock
  logic       ext_fall;   // one pulse per external clock falling edge
  logic       tick;       // one pulse per timer clock

  modport src (input clk_mode, input ext_fall, output tick);
  modport user (output clk_mode, output ext_fall, input tick);
endinterface : tcs_tick_if

// file: tcs_pin_sync.sv
`timescale 1ns/1ps
module tcs_pin_sync
  import tcs_pkg::*;
(
  input  wire logic clk_in,     // system clock
  input  wire logic srst_in,    // synchronous reset, high
  input  wire logic pin_in,     // asynchronous pin
  output logic      level_out,  // filtered level
  output logic      fall_out    // one pulse per falling edge
);

  logic s1;
  logic s2;
  logic s3;

  // three stages; only s2 reads s1, idle high so reset gives no edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once s2 and s3 agree
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      level_out <= 1'b1;
      fall_out  <= 1'b0;
    end else begin
      fall_out <= (s2 == s3) && !s2 && level_out;
      if (s2 == s3) begin
        level_out <= s2;
      end
    end
  end
endmodule : tcs_pin_sync

// file: tcs_prescale.sv
`timescale 1ns/1ps
module tcs_prescale
  import tcs_pkg::*;
(
  input  wire logic clk_in,   // system clock
  input  wire logic srst_in,  // synchronous reset, high
  tcs_tick_if.src   tk        // mode in, tick out
);

  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic       next_tick;

  // free running divider; a mode change keeps the count, so the first tick may come early
  always_comb begin
    next_div_cnt = div_cnt;
    next_tick    = 1'b0;
    case (tk.clk_mode)
      TCS_MODE_DIV12: begin
        next_tick    = (div_cnt >= TCS_DIV12_LAST);
        next_div_cnt = next_tick ? TCS_PRE_RESET : div_cnt + 4'h1;
      end
      TCS_MODE_DIV1: begin
        next_tick    = 1'b1;
        next_div_cnt = TCS_PRE_RESET;
      end
      TCS_MODE_EXT8: begin
        if (tk.ext_fall) begin
          next_tick    = (div_cnt >= TCS_EXT8_LAST);
          next_div_cnt = next_tick ? TCS_PRE_RESET : div_cnt + 4'h1;
        end
      end
      TCS_MODE_DIV2: begin
        next_tick    = (div_cnt >= TCS_DIV2_LAST);
        next_div_cnt = next_tick ? TCS_PRE_RESET : div_cnt + 4'h1;
      end
      default: begin
        next_div_cnt = TCS_PRE_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_cnt <= TCS_PRE_RESET;
      tk.tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tk.tick <= next_tick;
    end
  end
endmodule : tcs_prescale

// file: tcs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - capture mode counting up, rolling from all ones to zero sets the overflow flag.
// - auto-reload down count, reaching the reload value then all ones sets overflow.
// - capture mode down count, wrapping zero to all ones sets overflow.
// - overflow flag in bit 7 requests the interrupt; only software clears it.
// - external flag in bit 6 set by trigger falling edge capture or reload.
// - external enable bit 3 low stops trigger capture, reload and direction; counter mode still counts the pin.
// - capture mode, enabled trigger falling edge copies count to capture pair.
// - auto-reload, enabled, no decrement: trigger falling edge reloads and flags.
// - auto-reload, enabled, decrement on: trigger level sets direction, no reloads.
// - run bit 2 low stops the timer; high lets it count.
// - counter/timer select bit 1 low counts on the selected timer clock.
// - counter/timer select high counts each falling trigger edge.
// - bit 0 low selects auto-reload mode, high selects capture mode.
// - control at 0xC8 bit addressable and 0x91, both on page 0x10.
// - decrement enable low counts up; high counts down while trigger low and external enable set.
// - clock mode 00 div twelve, 01 undivided, 10 external div eight, 11 div two.
// - auto-reload down underflow loads all ones and keeps running.
// - auto-reload up overflow loads the reload pair and restarts.
module tcs_top
  import tcs_pkg::*;
(
  input  wire logic       clk_in,         // system clock, 25 MHz
  input  wire logic       srst_in,        // synchronous reset, high
  input  wire logic [7:0] sfr_page_in,    // register page of the access
  input  wire logic [7:0] sfr_addr_in,    // register address
  input  wire logic       sfr_wr_in,      // byte write strobe
  input  wire logic [7:0] sfr_wdata_in,   // byte write data
  input  wire logic       sfr_rd_in,      // read strobe
  input  wire logic       bit_wr_in,      // single bit write strobe
  input  wire logic [7:0] bit_addr_in,    // bit address
  input  wire logic       bit_data_in,    // bit write value
  input  wire logic [1:0] trig_pin_in,    // trigger pins, index 0 timer a
  input  wire logic       ext_clk_in,     // external clock pin
  output logic      [7:0] sfr_rdata_out,  // read data, one cycle after strobe
  output logic      [1:0] irq_out         // interrupt requests per timer
);

  // byte register hit on the timer page
  function automatic logic reg_hit(input logic [7:0] page,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    reg_hit = (page == TCS_PAGE) && (addr == target);
  endfunction : reg_hit

  logic [7:0]  ctl [TCS_NUM_TIMERS];
  logic [7:0]  cfg [TCS_NUM_TIMERS];
  logic [15:0] cap [TCS_NUM_TIMERS];
  logic [15:0] cnt [TCS_NUM_TIMERS];
  logic [7:0]  rd_word [TCS_NUM_TIMERS];
  logic [1:0]  rd_hit;
  logic        ext_level;
  logic        ext_fall;
  logic [7:0]  rd_mux;

  // external clock pin, shared by both prescalers
  tcs_pin_sync u_ext_sync (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .pin_in    (ext_clk_in),
    .level_out (ext_level),
    .fall_out  (ext_fall)
  );

  // one control path per timer; the two share only the bus and the external clock
  genvar gi;
  generate
    for (gi = 0; gi < TCS_NUM_TIMERS; gi++) begin : g_tmr
      logic        trig_level;
      logic        trig_fall;
      logic        run;
      logic        ct_sel;
      logic        cap_mode;
      logic        ext_en;
      logic        dcen;
      logic        down;
      logic        tick;
      logic        ext_evt;
      logic        cap_evt;
      logic        reload_evt;
      logic        ovf_evt;
      logic        ctl_wr;
      logic        bit_wr;
      logic        wr_cfg;
      logic        wr_capl;
      logic        wr_caph;
      logic        wr_cntl;
      logic        wr_cnth;
      logic        ext_set;
      logic        next_irq;
      logic [15:0] next_cnt;
      logic [15:0] next_cap;
      logic [7:0]  next_ctl;

      tcs_tick_if tk ();

      // trigger pin through the three-stage synchroniser
      tcs_pin_sync u_trig_sync (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .pin_in    (trig_pin_in[gi]),
        .level_out (trig_level),
        .fall_out  (trig_fall)
      );

      tcs_prescale u_pre (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .tk      (tk)
      );

      assign tk.clk_mode = cfg[gi][TCS_MODE_LSB +: 2];
      assign tk.ext_fall = ext_fall;

      // control fields
      assign run      = ctl[gi][TCS_RUN_BIT];
      assign ct_sel   = ctl[gi][TCS_CT_SEL_BIT];
      assign cap_mode = ctl[gi][TCS_CPRL_BIT];
      assign ext_en   = ctl[gi][TCS_EXT_EN_BIT];
      assign dcen     = cfg[gi][TCS_DCEN_BIT];

      // direction only follows the pin while external enable is on
      assign down = dcen && ext_en && !trig_level;
      // count source: timer clock or trigger falling edges
      assign tick = run && (ct_sel ? trig_fall : tk.tick);
      // gated trigger edge; with enable low the pin triggers no capture or reload
      assign ext_evt    = ext_en && trig_fall;
      assign cap_evt    = ext_evt && cap_mode;
      assign reload_evt = ext_evt && !cap_mode && !dcen;
      // either trigger action raises the external flag
      assign ext_set    = cap_evt || reload_evt;

      // overflow or underflow on this tick
      always_comb begin
        ovf_evt = 1'b0;
        if (tick) begin
          if (!down) begin
            ovf_evt = (cnt[gi] == TCS_ALL_ONES);
          end else if (cap_mode) begin
            ovf_evt = (cnt[gi] == TCS_ALL_ZEROS);
          end else begin
            ovf_evt = (cnt[gi] == cap[gi]);
          end
        end
      end

      // byte store decode, shared by the count, pair and configuration paths
      assign wr_cfg  = sfr_wr_in && reg_hit(sfr_page_in, sfr_addr_in, TCS_CFG_ADDR[gi]);
      assign wr_capl = sfr_wr_in && reg_hit(sfr_page_in, sfr_addr_in, TCS_CAPL_ADDR[gi]);
      assign wr_caph = sfr_wr_in && reg_hit(sfr_page_in, sfr_addr_in, TCS_CAPH_ADDR[gi]);
      assign wr_cntl = sfr_wr_in && reg_hit(sfr_page_in, sfr_addr_in, TCS_CNTL_ADDR[gi]);
      assign wr_cnth = sfr_wr_in && reg_hit(sfr_page_in, sfr_addr_in, TCS_CNTH_ADDR[gi]);

      // next count: software store, trigger reload, then counting
      always_comb begin
        next_cnt = cnt[gi];
        if (wr_cntl) begin
          next_cnt[7:0] = sfr_wdata_in;
        end else if (wr_cnth) begin
          next_cnt[15:8] = sfr_wdata_in;
        end else if (reload_evt) begin
          next_cnt = cap[gi];
        end else if (tick) begin
          if (!down) begin
            if (ovf_evt) begin
              next_cnt = cap_mode ? TCS_ALL_ZEROS : cap[gi];
            end else begin
              next_cnt = cnt[gi] + 16'h0001;
            end
          end else begin
            if (ovf_evt) begin
              next_cnt = TCS_ALL_ONES;
            end else begin
              next_cnt = cnt[gi] - 16'h0001;
            end
          end
        end
      end

      // capture wins over a software store in the same cycle
      always_comb begin
        next_cap = cap[gi];
        if (cap_evt) begin
          next_cap = cnt[gi];
        end else if (wr_capl) begin
          next_cap[7:0] = sfr_wdata_in;
        end else if (wr_caph) begin
          next_cap[15:8] = sfr_wdata_in;
        end
      end

      // control write paths; only timer a has bit access
      assign ctl_wr = sfr_wr_in && reg_hit(sfr_page_in, sfr_addr_in, TCS_CTL_ADDR[gi]);
      assign bit_wr = (gi == 0) && bit_wr_in && (sfr_page_in == TCS_PAGE)
                      && (bit_addr_in[7:3] == TCS_BIT_GROUP_A);

      // stores first, hardware sets ORed last so a set never gets lost
      always_comb begin
        next_ctl = ctl[gi];
        if (ctl_wr) begin
          next_ctl = sfr_wdata_in & TCS_CTL_MASK;
        end else if (bit_wr) begin
          next_ctl[bit_addr_in[2:0]] = bit_data_in;
          next_ctl = next_ctl & TCS_CTL_MASK;
        end
        if (ovf_evt) begin
          next_ctl[TCS_OVF_BIT] = 1'b1;
        end
        if (ext_set) begin
          next_ctl[TCS_EXT_FLAG_BIT] = 1'b1;
        end
      end

      // control register
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          ctl[gi] <= TCS_CTL_RESET;
        end else begin
          ctl[gi] <= next_ctl;
        end
      end

      // configuration register: clock mode and decrement enable
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          cfg[gi] <= TCS_CFG_RESET;
        end else if (wr_cfg) begin
          cfg[gi] <= sfr_wdata_in & TCS_CFG_MASK;
        end
      end

      // count and capture/reload pair
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          cnt[gi] <= TCS_WORD_RESET;
          cap[gi] <= TCS_WORD_RESET;
        end else begin
          cnt[gi] <= next_cnt;
          cap[gi] <= next_cap;
        end
      end

      // interrupt request: overflow, plus external flag in capture mode; taken from
      // the next control value so the request never lags the flags by a cycle
      assign next_irq = next_ctl[TCS_OVF_BIT]
                        || (next_ctl[TCS_EXT_FLAG_BIT] && next_ctl[TCS_CPRL_BIT]);

      // registered request
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          irq_out[gi] <= 1'b0;
        end else begin
          irq_out[gi] <= next_irq;
        end
      end

      // read selection for this timer
      always_comb begin
        rd_hit[gi]  = 1'b1;
        rd_word[gi] = 8'h00;
        if (reg_hit(sfr_page_in, sfr_addr_in, TCS_CTL_ADDR[gi])) begin
          rd_word[gi] = ctl[gi];
        end else if (reg_hit(sfr_page_in, sfr_addr_in, TCS_CFG_ADDR[gi])) begin
          rd_word[gi] = cfg[gi];
        end else if (reg_hit(sfr_page_in, sfr_addr_in, TCS_CAPL_ADDR[gi])) begin
          rd_word[gi] = cap[gi][7:0];
        end else if (reg_hit(sfr_page_in, sfr_addr_in, TCS_CAPH_ADDR[gi])) begin
          rd_word[gi] = cap[gi][15:8];
        end else if (reg_hit(sfr_page_in, sfr_addr_in, TCS_CNTL_ADDR[gi])) begin
          rd_word[gi] = cnt[gi][7:0];
        end else if (reg_hit(sfr_page_in, sfr_addr_in, TCS_CNTH_ADDR[gi])) begin
          rd_word[gi] = cnt[gi][15:8];
        end else begin
          rd_hit[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // pick the timer that claims the address; the two maps never overlap, so
  // the order of the loop does not matter
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < TCS_NUM_TIMERS; i++) begin
      if (rd_hit[i]) begin
        rd_mux = rd_word[i];
      end
    end
  end

  // read data held until the next read; unmapped reads return zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= rd_mux;
    end
  end

endmodule : tcs_top

// file: tcs_sva.sv
`timescale 1ns/1ps
// watches the register bus and the request lines only
module tcs_sva (
  input wire logic       clk_in,         // system clock
  input wire logic       srst_in,        // synchronous reset
  input wire logic [7:0] sfr_page_in,    // page
  input wire logic [7:0] sfr_addr_in,    // address
  input wire logic       sfr_wr_in,      // byte write
  input wire logic       sfr_rd_in,      // read strobe
  input wire logic       bit_wr_in,      // bit write
  input wire logic [7:0] sfr_rdata_out,  // read data
  input wire logic [1:0] irq_out         // requests
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic pg;
  logic mapped;
  // decode kept apart so every property that checks the page or map reads the same pg and mapped
  assign pg     = (sfr_page_in == 8'h10);
  assign mapped = sfr_addr_in inside {[8'hC8:8'hCD], [8'h91:8'h96]};

  rst_clear_a: assert property (disable iff (1'b0) srst_in |=>
    sfr_rdata_out == 8'h00 && irq_out == 2'b00) else $error("reset left outputs set");
  rd_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved without a read");
  page_refuse_a: assert property (sfr_rd_in && !pg |=> sfr_rdata_out == 8'h00)
    else $error("foreign page answered");
  unmap_refuse_a: assert property (sfr_rd_in && pg && !mapped |=>
    sfr_rdata_out == 8'h00) else $error("unmapped address answered");
  ctl_resv_a: assert property (sfr_rd_in && pg && sfr_addr_in inside {8'hC8, 8'h91}
    |=> sfr_rdata_out[5:4] == 2'b00) else $error("control reserved bits set");
  cfg_resv_a: assert property (sfr_rd_in && pg && sfr_addr_in inside {8'hC9, 8'h96}
    |=> (sfr_rdata_out & 8'hE6) == 8'h00) else $error("config reserved bits set");
  irq_hold_a: assert property (irq_out[1] && !sfr_wr_in && !$past(sfr_wr_in)
    |=> irq_out[1]) else $error("request dropped without software");
  irq_fall_a: assert property ($fell(irq_out[0]) && !$past(srst_in) |->
    $past(sfr_wr_in || bit_wr_in)) else $error("request cleared by hardware");
endmodule : tcs_sva

// file: tcs_pin_model.sv
`timescale 1ns/1ps
// stands in for the trigger pins and the external clock source
module tcs_pin_model (
  input  wire logic       clk_in,       // system clock
  input  wire logic [1:0] fall_in,      // request one low pulse
  input  wire logic [1:0] hold_in,      // keep pin low
  input  wire logic       ext_run_in,   // run external clock
  output logic      [1:0] trig_out,     // trigger pins
  output logic            ext_clk_out   // external clock
);
  logic [2:0] low_cnt [2] = '{3'h0, 3'h0};
  logic [1:0] ext_div     = 2'h0;
  initial trig_out = 2'b11;
  initial ext_clk_out = 1'b0;
  // pulses stay low five cycles so the synchroniser sees exactly one edge
  always @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (fall_in[i]) low_cnt[i] <= 3'h5;
      else if (low_cnt[i] != 3'h0) low_cnt[i] <= low_cnt[i] - 3'h1;
      trig_out[i] <= !(hold_in[i] || fall_in[i] || low_cnt[i] > 3'h1);
    end
  end
  // clock of eight system cycles, held low while not wanted
  always @(posedge clk_in) begin
    ext_div <= ext_div + 2'h1;
    if (!ext_run_in) ext_clk_out <= 1'b0;
    else if (ext_div == 2'h3) ext_clk_out <= !ext_clk_out;
  end
endmodule : tcs_pin_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  logic       clk_in;
  logic       srst_in;
  logic [7:0] sfr_page_in;
  logic [7:0] sfr_addr_in;
  logic       sfr_wr_in;
  logic [7:0] sfr_wdata_in;
  logic       sfr_rd_in;
  logic       bit_wr_in;
  logic [7:0] bit_addr_in;
  logic       bit_data_in;
  logic [1:0] trig_pin_in;
  logic       ext_clk_in;
  logic [7:0] sfr_rdata_out;
  logic [1:0] irq_out;
  logic [1:0] fall_req;
  logic [1:0] hold_req;
  logic       ext_run;
  int         err_count;
  int         samples_checked;

  tcs_top DUT (.clk_in(clk_in), .srst_in(srst_in), .sfr_page_in(sfr_page_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rd_in(sfr_rd_in), .bit_wr_in(bit_wr_in), .bit_addr_in(bit_addr_in),
    .bit_data_in(bit_data_in), .trig_pin_in(trig_pin_in), .ext_clk_in(ext_clk_in),
    .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out));
  tcs_pin_model u_pins (.clk_in(clk_in), .fall_in(fall_req), .hold_in(hold_req),
    .ext_run_in(ext_run), .trig_out(trig_pin_in), .ext_clk_out(ext_clk_in));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = !clk_in;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] pg = 8'h10);
    @(posedge clk_in);
    sfr_page_in  <= pg;
    sfr_addr_in  <= a;
    sfr_wdata_in <= d;
    sfr_wr_in    <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in    <= 1'b0;
  endtask : wr

  // data lands on the strobe's edge, so look just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [7:0] pg = 8'h10);
    @(posedge clk_in);
    sfr_page_in <= pg;
    sfr_addr_in <= a;
    sfr_rd_in   <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in   <= 1'b0;
    #1 d = sfr_rdata_out;
  endtask : rd

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp,
                      input logic [7:0] pg = 8'h10);
    logic [7:0] d;
    rd(a, d, pg);
    check(name, 16'(d), 16'(exp));
  endtask : rchk

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk_in);
    bit_addr_in <= a;
    bit_data_in <= v;
    bit_wr_in   <= 1'b1;
    @(posedge clk_in);
    bit_wr_in   <= 1'b0;
  endtask : bw

  // pins need several stable cycles per level, hence the long gap
  task automatic pulse(input int i);
    @(posedge clk_in);
    fall_req[i] <= 1'b1;
    @(posedge clk_in);
    fall_req[i] <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask : pulse

  task automatic t_reset;
    for (int i = 0; i < 2; i++) begin
      rchk("ctl", TCS_CTL_ADDR[i], 8'h00);
      rchk("cfg", TCS_CFG_ADDR[i], 8'h00);
      rchk("capl", TCS_CAPL_ADDR[i], 8'h00);
      rchk("cnth", TCS_CNTH_ADDR[i], 8'h00);
    end
    wr(8'hC8, 8'hFF, 8'h00);
    rchk("foreign_wr", 8'hC8, 8'h00);
    rchk("foreign_rd", 8'hC8, 8'h00, 8'h20);
    rchk("unmapped", 8'hC7, 8'h00);
  endtask : t_reset

  task automatic t_access;
    for (int i = 0; i < 2; i++) begin
      wr(TCS_CTL_ADDR[i], 8'hFF);
      rchk("ctl_all", TCS_CTL_ADDR[i], TCS_CTL_MASK);
      check("irq_store", 16'(irq_out[i]), 16'h1);
      wr(TCS_CTL_ADDR[i], 8'h00);
      rchk("ctl_clr", TCS_CTL_ADDR[i], 8'h00);
      wr(TCS_CFG_ADDR[i], 8'hFF);
      rchk("cfg_all", TCS_CFG_ADDR[i], TCS_CFG_MASK);
      wr(TCS_CFG_ADDR[i], 8'h00);
    end
  endtask : t_access

  task automatic t_overflow;
    wr(8'hC9, 8'h08);
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    repeat (20) @(posedge clk_in);
    rchk("idle_flag", 8'hC8, 8'h00);
    wr(8'hC8, 8'h04);
    repeat (8) @(posedge clk_in);
    rchk("ovf_up", 8'hC8, 8'h84);
    wr(8'hC8, 8'h80);
    rchk("reload", 8'hCD, 8'h12);
    check("irq_ovf", 16'(irq_out[0]), 16'h1);
    wr(8'hCC, 8'h10);
    repeat (20) @(posedge clk_in);
    rchk("stopped", 8'hCC, 8'h10);
    wr(8'hC8, 8'h00);
  endtask : t_overflow

  task automatic t_down;
    wr(8'h94, 8'h01);
    wr(8'h95, 8'h00);
    wr(8'h96, 8'h09);
    wr(8'h91, 8'h09);
    @(posedge clk_in);
    hold_req <= 2'b10;
    repeat (12) @(posedge clk_in);
    rchk("ext_flag", 8'h91, 8'h49);
    rchk("captured", 8'h92, 8'h01);
    wr(8'h91, 8'h4D);
    repeat (8) @(posedge clk_in);
    rchk("underflow", 8'h91, 8'hCD);
    wr(8'h91, 8'hC9);
    rchk("down_cnt", 8'h95, 8'hFF);
    hold_req <= 2'b00;
    repeat (12) @(posedge clk_in);
    wr(8'h91, 8'h00);
    // auto-reload counting down: the pin steers only, the match with the pair underflows
    wr(8'h92, 8'h05);
    wr(8'h93, 8'h00);
    wr(8'h94, 8'h08);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h08);
    hold_req <= 2'b10;
    repeat (12) @(posedge clk_in);
    rchk("no_reload", 8'h94, 8'h08);
    rchk("no_ext", 8'h91, 8'h08);
    wr(8'h91, 8'h0C);
    repeat (8) @(posedge clk_in);
    rchk("rl_under", 8'h91, 8'h8C);
    wr(8'h91, 8'h88);
    rchk("rl_ones", 8'h95, 8'hFF);
    hold_req <= 2'b00;
    repeat (12) @(posedge clk_in);
    wr(8'h91, 8'h00);
  endtask : t_down

  task automatic t_trigger;
    wr(8'hC8, 8'h01);
    pulse(0);
    rchk("off_flag", 8'hC8, 8'h01);
    rchk("off_cap", 8'hCA, 8'h34);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h08);
    pulse(0);
    rchk("trig_rl", 8'hC8, 8'h48);
    rchk("rl_high", 8'hCD, 8'h12);
    rchk("rl_low", 8'hCC, 8'h34);
    wr(8'hC8, 8'h00);
  endtask : t_trigger

  task automatic t_counter;
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h96, 8'h00);
    wr(8'h91, 8'h06);
    for (int k = 0; k < 3; k++) pulse(1);
    wr(8'h91, 8'h00);
    rchk("events", 8'h94, 8'h03);
  endtask : t_counter

  task automatic t_bits;
    bw(8'hCA, 1'b1);
    rchk("bit_run", 8'hC8, 8'h04);
    bw(8'hCC, 1'b1);
    bw(8'hCF, 1'b1);
    rchk("bit_resv", 8'hC8, 8'h84);
    bw(8'hCA, 1'b0);
    bw(8'hCF, 1'b0);
    rchk("bit_clr", 8'hC8, 8'h00);
  endtask : t_bits

  // windows of 98 cycles; the prescaler phase is free, so div twelve and external modes may gain one tick
  task automatic t_modes;
    logic [7:0] lo [4]    = '{8'd8, 8'd98, 8'd1, 8'd49};
    logic [7:0] slack [4] = '{8'd1, 8'd0, 8'd1, 8'd0};
    logic [7:0] got;
    for (int m = 0; m < 4; m++) begin
      wr(8'hC9, {3'h0, 2'(m), 3'h0});
      wr(8'hCC, 8'h00);
      ext_run <= (m == 2);
      wr(8'hC8, 8'h04);
      repeat (96) @(posedge clk_in);
      wr(8'hC8, 8'h00);
      ext_run <= 1'b0;
      rd(8'hCC, got);
      check("mode_cnt", 16'(got >= lo[m] && got <= lo[m] + slack[m]), 16'h1);
    end
  endtask : t_modes

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    {srst_in, sfr_page_in, sfr_addr_in, sfr_wr_in, sfr_wdata_in} = {1'b1, 25'h0};
    {sfr_rd_in, bit_wr_in, bit_addr_in, bit_data_in} = 11'h0;
    {fall_req, hold_req, ext_run} = 5'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_access();
    t_overflow();
    t_down();
    t_trigger();
    t_counter();
    t_bits();
    t_modes();
    report_and_stop();
  end
endmodule : tb

bind tcs_top tcs_sva u_sva (.clk_in(clk_in), .srst_in(srst_in), .sfr_page_in(sfr_page_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .bit_wr_in(bit_wr_in), .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out));
